// *** design/rtu_link_pkg.sv ***
// shared constants, carriers and helpers for the rtu slave link
package rtu_link_pkg;
	localparam int CLK_HZ = 25_000_000;
	localparam int MS_PER_S = 1000;
	localparam int BAUD_9K6 = 9600;
	localparam int BAUD_19K2 = 19200;
	localparam int BAUD_38K4 = 38400;
	localparam int BAUD_57K6 = 57600;
	localparam int BAUD_115K2 = 115200;
	localparam logic [11:0] BIT_CYC_9K6 = 12'(CLK_HZ / BAUD_9K6);
	localparam logic [11:0] BIT_CYC_19K2 = 12'(CLK_HZ / BAUD_19K2);
	localparam logic [11:0] BIT_CYC_38K4 = 12'(CLK_HZ / BAUD_38K4);
	localparam logic [11:0] BIT_CYC_57K6 = 12'(CLK_HZ / BAUD_57K6);
	localparam logic [11:0] BIT_CYC_115K2 = 12'(CLK_HZ / BAUD_115K2);
	localparam logic [2:0] BAUD_CODE_9K6 = 3'h3;
	localparam logic [2:0] BAUD_CODE_19K2 = 3'h4;
	localparam logic [2:0] BAUD_CODE_38K4 = 3'h5;
	localparam logic [2:0] BAUD_CODE_57K6 = 3'h6;
	localparam logic [2:0] BAUD_CODE_115K2 = 3'h7;
	localparam logic [1:0] PAR_NONE = 2'h0;
	localparam logic [1:0] PAR_EVEN = 2'h1;
	localparam logic [1:0] PAR_ODD = 2'h2;
	// 3.5 characters of 11 bits, counted in half bits
	localparam int GAP_HALF_BITS = 77;
	localparam logic [3:0] RX_START_BIT = 4'h0;
	localparam logic [3:0] RX_DATA_LAST = 4'h8;
	localparam logic [3:0] RX_PAR_BIT = 4'h9;
	localparam logic [3:0] TX_LAST_BIT = 4'hA;
	localparam logic [6:0] DELAY_MS_DEF = 7'h05;
	localparam logic [6:0] DELAY_MS_MAX = 7'h63;
	localparam logic [5:0] UNIT_DEF = 6'h01;
	localparam logic PROTO_RTU = 1'b1;
	localparam int SWB_FORCE_BIT = 2;
	localparam logic [1:0] CFG_SETTLE = 2'h3;
	localparam logic [7:0] ADDR_BCAST = 8'h00;
	localparam logic [7:0] FC_READ = 8'h03;
	localparam logic [7:0] FC_WRITE = 8'h10;
	localparam logic [7:0] FC_SINGLE = 8'h06;
	localparam logic [7:0] FC_ECHO = 8'h08;
	localparam logic [7:0] FC_ERR_FLAG = 8'h80;
	localparam logic [7:0] ERR_BAD_FUNC = 8'h01;
	localparam logic [15:0] CRC_PRESET = 16'hFFFF;
	localparam logic [15:0] CRC_POLY = 16'hA001;
	localparam logic [15:0] CRC_RESIDUE = 16'h0000;
	localparam logic [8:0] FRAME_MIN = 9'h004;
	localparam logic [8:0] FRAME_MAX = 9'h100;
	localparam logic [8:0] IDX_ADDR = 9'h000;
	localparam logic [8:0] IDX_FUNC = 9'h001;

	typedef struct packed {
		logic protocol;
		logic [2:0] baud;
		logic [1:0] parity;
		logic [6:0] delay_ms;
	} link_cfg_t;
	localparam link_cfg_t CFG_DEFAULT = '{protocol: PROTO_RTU, baud: BAUD_CODE_9K6,
		parity: PAR_EVEN, delay_ms: DELAY_MS_DEF};

	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} rx_byte_t;

	typedef struct packed {
		logic good;
		logic drop;
		logic bcast;
		logic [7:0] func;
	} frame_info_t;

	typedef struct packed {
		logic start;
		logic error;
		logic [7:0] code;
	} resp_req_t;

	typedef struct packed {
		logic valid;
		logic last;
		logic [7:0] data;
	} tx_byte_t;

	function automatic logic [11:0] bit_cycles(input logic [2:0] code);
		case (code)
			BAUD_CODE_19K2: bit_cycles = BIT_CYC_19K2;
			BAUD_CODE_38K4: bit_cycles = BIT_CYC_38K4;
			BAUD_CODE_57K6: bit_cycles = BIT_CYC_57K6;
			BAUD_CODE_115K2: bit_cycles = BIT_CYC_115K2;
			default: bit_cycles = BIT_CYC_9K6;
		endcase
	endfunction

	function automatic logic is_supported(input logic [7:0] fc);
		is_supported = (fc == FC_READ) || (fc == FC_WRITE) || (fc == FC_SINGLE) || (fc == FC_ECHO);
	endfunction

	// ninth bit of a character: parity, or the extra stop bit
	function automatic logic ninth_bit(input logic [1:0] par, input logic [7:0] d);
		case (par)
			PAR_EVEN: ninth_bit = ^d;
			PAR_ODD: ninth_bit = ~^d;
			default: ninth_bit = 1'b1;
		endcase
	endfunction
endpackage

// *** design/crc16_byte_step.sv ***
// one byte step of the reflected crc-16
module crc16_byte_step import rtu_link_pkg::*; (
	input wire logic [15:0] crc_in,
	input wire logic [7:0] data_in,
	output logic [15:0] crc_out
);
	always_comb begin
		logic [15:0] c;
		c = crc_in ^ {8'h00, data_in};
		for (int i = 0; i < 8; i++) begin
			if (c[0]) begin
				c = (c >> 1) ^ CRC_POLY;
			end else begin
				c = c >> 1;
			end
		end
		crc_out = c;
	end
endmodule // crc16_byte_step

// *** design/rtu_serial_slave_link.sv ***
// slave link layer of the rtu serial port: framing, filtering, check code, responses
// What this block does
// - six-bit unit number; accept own or broadcast
// - baud codes 3..7 select 9.6..115.2k
// - parity code: none, even, odd; even default
// - eight data bits; stops follow parity setting
// - wait programmed milliseconds, at most 99, before driving line
// - settings latched only after reset
// - protocol code or switch forces this link
// - frames bounded by 3.5 character silence
// - broadcast executed but never answered
// - function code follows the address byte
// - check code covers address through data
// - check register starts at all ones
// - per byte xor, eight reflected shifts
// - check code sent low byte first
// - answer starts with own unit number
// - echo function; errors set its top bit
// - error answer carries one error byte
// - foreign address frames get no bytes, no good/drop flag and no answer; their function code still updates info.func
// - character errors drop the whole frame
// - bad check code drops the frame
// - long gap abandons a frame
// - four function codes are recognised
// - unknown function answered with error 01
module rtu_serial_slave_link import rtu_link_pkg::*; #(
	parameter int MS_CYCLES = CLK_HZ / MS_PER_S
) (
	// clock, reset, enable
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire logic clk_en_in,
	// serial line pins
	input wire logic rx_pin_in,
	output logic tx_pin_out,
	output logic tx_drive_en_out,
	// front switches
	input wire logic [3:0] unit_address_switch_a_in,
	input wire logic [3:0] unit_address_switch_b_in,
	// stored settings
	input wire link_cfg_t cfg_stored_in,
	// received frame to command logic
	output rx_byte_t rx_byte_out,
	output frame_info_t frame_info_out,
	output logic link_active_out,
	// response from command logic
	input wire resp_req_t resp_req_in,
	input wire tx_byte_t resp_byte_in,
	output logic resp_byte_ready_out
);
	typedef enum logic [6:0] {
		L_CFG = 7'h01,
		L_HUNT = 7'h02,
		L_IDLE = 7'h04,
		L_RECV = 7'h08,
		L_WAIT_APP = 7'h10,
		L_DELAY = 7'h20,
		L_SEND = 7'h40
	} link_state_t;

	typedef enum logic [6:0] {
		P_ADDR = 7'h01,
		P_FUNC = 7'h02,
		P_BODY = 7'h04,
		P_CRCL = 7'h08,
		P_CRCH = 7'h10,
		P_DONE = 7'h20,
		P_GUARD = 7'h40
	} tx_phase_t;

	typedef struct packed {
		logic [1:0] cfg_wait;
		link_cfg_t cfg;
		logic [5:0] unit;
		logic active;
		logic [11:0] bit_cyc;
		logic [16:0] gap_cyc;
		logic [7:0] sw_s1;
		logic [7:0] sw_s2;
		logic sync1;
		logic sync2;
		logic rx_prev;
		logic rx_busy;
		logic [11:0] rx_cnt;
		logic [3:0] rx_bit;
		logic [7:0] rx_sh;
		logic rx_perr;
		logic [16:0] gap_cnt;
		link_state_t link;
		logic [8:0] idx;
		logic bad;
		logic ignore;
		logic [7:0] addr;
		logic [15:0] rx_crc;
		logic resp_err;
		logic [7:0] resp_code;
		logic [6:0] ms_cnt;
		logic [16:0] dcnt;
		tx_phase_t phase;
		logic tx_busy;
		logic [11:0] tx_cnt;
		logic [3:0] tx_bit;
		logic [10:0] tx_sh;
		logic [15:0] tx_crc;
		logic tx_line;
		logic tx_en;
		logic data_ready;
		rx_byte_t rx_out;
		frame_info_t info;
	} state_t;

	state_t r;
	state_t n;
	logic byte_ev;
	logic char_err;
	logic gap_hit;
	logic frame_ok;
	logic tx_load;
	logic [7:0] tx_byte;
	logic [15:0] rx_crc_step;
	logic [15:0] tx_crc_step;
	logic [11:0] bc;

	crc16_byte_step u_rx_crc (
		.crc_in(r.rx_crc),
		.data_in(r.rx_sh),
		.crc_out(rx_crc_step)
	);

	crc16_byte_step u_tx_crc (
		.crc_in(r.tx_crc),
		.data_in(tx_byte),
		.crc_out(tx_crc_step)
	);

	assign bc = bit_cycles(cfg_stored_in.baud);
	assign gap_hit = r.gap_cnt >= r.gap_cyc;
	assign frame_ok = !r.bad && !r.ignore && r.idx >= FRAME_MIN && r.rx_crc == CRC_RESIDUE;

	always_comb begin
		n = r;
		byte_ev = 1'b0;
		char_err = 1'b0;
		tx_load = 1'b0;
		tx_byte = 8'h00;
		n.rx_out.valid = 1'b0;
		n.info.good = 1'b0;
		n.info.drop = 1'b0;
		// pins pass two flops before anything reads them
		n.sw_s1 = {unit_address_switch_b_in, unit_address_switch_a_in};
		n.sw_s2 = r.sw_s1;
		n.sync1 = rx_pin_in;
		n.sync2 = r.sync1;
		n.rx_prev = r.sync2;

		// receiver: 11 bit frame, sampled mid bit
		if (!r.rx_busy) begin
			if (r.rx_prev && !r.sync2) begin
				n.rx_busy = 1'b1;
				n.rx_bit = RX_START_BIT;
				n.rx_cnt = r.bit_cyc >> 1;
				n.rx_perr = 1'b0;
			end
		end else if (r.rx_cnt != 12'h000) begin
			n.rx_cnt = r.rx_cnt - 12'h001;
		end else begin
			n.rx_cnt = r.bit_cyc - 12'h001;
			n.rx_bit = r.rx_bit + 4'h1;
			if (r.rx_bit == RX_START_BIT) begin
				// a glitch shorter than half a bit is not a start
				if (r.sync2) begin
					n.rx_busy = 1'b0;
				end
			end else if (r.rx_bit <= RX_DATA_LAST) begin
				n.rx_sh = {r.sync2, r.rx_sh[7:1]};
			end else if (r.rx_bit == RX_PAR_BIT && r.cfg.parity != PAR_NONE) begin
				n.rx_perr = ninth_bit(r.cfg.parity, r.rx_sh) != r.sync2;
			end else begin
				// one stop bit is checked; a second one just reads as idle
				n.rx_busy = 1'b0;
				byte_ev = 1'b1;
				char_err = r.rx_perr || !r.sync2;
			end
		end

		// silence measured from the end of each character
		if (r.rx_busy || (r.rx_prev && !r.sync2)) begin
			n.gap_cnt = 17'h00000;
		end else if (!gap_hit) begin
			n.gap_cnt = r.gap_cnt + 17'h00001;
		end

		// transmitter shift
		if (r.tx_busy) begin
			if (r.tx_cnt != 12'h000) begin
				n.tx_cnt = r.tx_cnt - 12'h001;
			end else begin
				n.tx_cnt = r.bit_cyc - 12'h001;
				n.tx_bit = r.tx_bit + 4'h1;
				n.tx_sh = {1'b1, r.tx_sh[10:1]};
				n.tx_line = r.tx_sh[1];
				if (r.tx_bit == TX_LAST_BIT) begin
					n.tx_busy = 1'b0;
					n.tx_line = 1'b1;
				end
			end
		end

		case (r.link)
			L_CFG: begin
				n.cfg_wait = r.cfg_wait + 2'h1;
				if (r.cfg_wait == CFG_SETTLE) begin
					n.cfg = cfg_stored_in;
					if (cfg_stored_in.delay_ms > DELAY_MS_MAX) begin
						n.cfg.delay_ms = DELAY_MS_MAX;
					end
					n.unit = {r.sw_s2[5:4], r.sw_s2[3:0]};
					n.active = cfg_stored_in.protocol == PROTO_RTU || r.sw_s2[4 + SWB_FORCE_BIT];
					n.bit_cyc = bc;
					n.gap_cyc = 17'((32'(bc) * GAP_HALF_BITS + 1) / 2);
					n.link = L_HUNT;
				end
			end
			L_HUNT: begin
				if (gap_hit && r.active) begin
					n.link = L_IDLE;
				end
			end
			L_IDLE, L_RECV: begin
				if (byte_ev) begin
					n.link = L_RECV;
					n.rx_crc = rx_crc_step;
					if (r.idx != FRAME_MAX) begin
						n.idx = r.idx + 9'h001;
					end
					// a frame too long for the counter counts as overrun
					if (char_err || r.idx == FRAME_MAX) begin
						n.bad = 1'b1;
					end
					if (r.idx == IDX_ADDR) begin
						n.addr = r.rx_sh;
						if (r.rx_sh != {2'b00, r.unit} && r.rx_sh != ADDR_BCAST) begin
							n.ignore = 1'b1;
						end
					end
					if (r.idx == IDX_FUNC) begin
						n.info.func = r.rx_sh;
					end
					if (r.idx > IDX_FUNC && !r.ignore) begin
						n.rx_out.valid = 1'b1;
						n.rx_out.data = r.rx_sh;
					end
				end else if (r.link == L_RECV && gap_hit) begin
					// the closing silence ends the frame; later bytes start a new one
					n.info.good = frame_ok;
					n.info.drop = !frame_ok && !r.ignore;
					n.info.bcast = r.addr == ADDR_BCAST;
					n.link = L_IDLE;
					n.idx = IDX_ADDR;
					n.bad = 1'b0;
					n.ignore = 1'b0;
					n.rx_crc = CRC_PRESET;
					n.resp_err = 1'b0;
					if (frame_ok && r.addr != ADDR_BCAST) begin
						if (!is_supported(r.info.func)) begin
							n.resp_err = 1'b1;
							n.resp_code = ERR_BAD_FUNC;
							n.link = L_DELAY;
							n.ms_cnt = r.cfg.delay_ms;
							n.dcnt = 17'h00000;
						end else begin
							n.link = L_WAIT_APP;
						end
					end
				end
			end
			L_WAIT_APP: begin
				if (resp_req_in.start) begin
					n.resp_err = resp_req_in.error;
					n.resp_code = resp_req_in.code;
					n.link = L_DELAY;
					n.ms_cnt = r.cfg.delay_ms;
					n.dcnt = 17'h00000;
				end
			end
			L_DELAY: begin
				if (r.ms_cnt == 7'h00) begin
					n.link = L_SEND;
					n.phase = P_ADDR;
					n.tx_en = 1'b1;
					n.tx_crc = CRC_PRESET;
				end else if (r.dcnt == 17'(MS_CYCLES - 1)) begin
					n.dcnt = 17'h00000;
					n.ms_cnt = r.ms_cnt - 7'h01;
				end else begin
					n.dcnt = r.dcnt + 17'h00001;
				end
			end
			L_SEND: begin
				if (!r.tx_busy) begin
					case (r.phase)
						P_ADDR: begin
							tx_load = 1'b1;
							tx_byte = {2'b00, r.unit};
							n.phase = P_FUNC;
						end
						P_FUNC: begin
							tx_load = 1'b1;
							tx_byte = r.resp_err ? (r.info.func | FC_ERR_FLAG) : r.info.func;
							n.phase = P_BODY;
						end
						P_BODY: begin
							if (r.resp_err) begin
								tx_load = 1'b1;
								tx_byte = r.resp_code;
								n.phase = P_CRCL;
							end else if (r.data_ready && resp_byte_in.valid) begin
								tx_load = 1'b1;
								tx_byte = resp_byte_in.data;
								if (resp_byte_in.last) begin
									n.phase = P_CRCL;
								end
							end
						end
						P_CRCL: begin
							tx_load = 1'b1;
							tx_byte = r.tx_crc[7:0];
							n.phase = P_CRCH;
						end
						P_CRCH: begin
							tx_load = 1'b1;
							tx_byte = r.tx_crc[15:8];
							n.phase = P_DONE;
						end
						P_DONE: begin
							n.tx_en = 1'b0;
							n.dcnt = 17'h00000;
							n.phase = P_GUARD;
						end
						P_GUARD: begin
							// own closing silence before listening again
							if (r.dcnt >= r.gap_cyc) begin
								n.link = L_IDLE;
							end else begin
								n.dcnt = r.dcnt + 17'h00001;
							end
						end
						default: n.phase = P_DONE;
					endcase
				end
				if (tx_load) begin
					n.tx_busy = 1'b1;
					n.tx_bit = RX_START_BIT;
					n.tx_cnt = r.bit_cyc - 12'h001;
					n.tx_line = 1'b0;
					n.tx_sh = {1'b1, ninth_bit(r.cfg.parity, tx_byte), tx_byte, 1'b0};
					if (r.phase != P_CRCL && r.phase != P_CRCH) begin
						n.tx_crc = tx_crc_step;
					end
				end
			end
			default: n.link = L_CFG;
		endcase
		n.data_ready = n.link == L_SEND && n.phase == P_BODY && !n.resp_err && !n.tx_busy;
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			r <= '0;
			r.cfg <= CFG_DEFAULT;
			r.unit <= UNIT_DEF;
			r.link <= L_CFG;
			r.phase <= P_GUARD;
			r.rx_crc <= CRC_PRESET;
			r.sync1 <= 1'b1;
			r.sync2 <= 1'b1;
			r.rx_prev <= 1'b1;
			r.tx_line <= 1'b1;
		end else if (clk_en_in) begin
			r <= n;
		end
	end

	assign tx_pin_out = r.tx_line;
	assign tx_drive_en_out = r.tx_en;
	assign rx_byte_out = r.rx_out;
	assign frame_info_out = r.info;
	assign link_active_out = r.active;
	assign resp_byte_ready_out = r.data_ready;

	a_unit_first: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		tx_load && r.phase == P_ADDR |-> r.tx_crc == CRC_PRESET && tx_byte[5:0] == r.unit)
		else $error("response does not open with own unit number");
	a_err_func_flag: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		tx_load && r.phase == P_FUNC |-> tx_byte[7] == (r.resp_err | r.info.func[7]))
		else $error("function byte error flag wrong");
	a_crc_low_first: assert property (@(posedge core_clk_in) disable iff (!rst_n_in || !clk_en_in)
		tx_load && r.phase == P_CRCL |=> r.phase == P_CRCH && r.tx_sh[8:1] == $past(r.tx_crc[7:0]))
		else $error("check code low byte not sent first");
	a_idle_preset: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		r.link == L_IDLE |-> r.rx_crc == CRC_PRESET && r.idx == IDX_ADDR)
		else $error("receive check register not preset");
	a_delay_quiet: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		r.link == L_DELAY || r.link == L_WAIT_APP |-> !tx_drive_en_out && tx_pin_out)
		else $error("driver enabled during response delay");
	a_bcast_silent: assert property (@(posedge core_clk_in) disable iff (!rst_n_in || !clk_en_in)
		frame_info_out.good && frame_info_out.bcast |-> r.link == L_IDLE ##1 r.link == L_IDLE)
		else $error("broadcast frame answered");
	a_drop_silent: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		frame_info_out.drop |-> !frame_info_out.good && r.link == L_IDLE && !tx_drive_en_out)
		else $error("dropped frame not silent");
	a_foreign_quiet: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		r.ignore |-> !rx_byte_out.valid && !frame_info_out.good)
		else $error("foreign frame passed on");
	a_stop_bits: assert property (@(posedge core_clk_in) disable iff (!rst_n_in || !clk_en_in)
		tx_load |=> r.tx_sh[10] && r.tx_sh[9] == ninth_bit(r.cfg.parity, r.tx_sh[8:1]) && !tx_pin_out)
		else $error("character framing wrong");
	a_cfg_frozen: assert property (@(posedge core_clk_in) disable iff (!rst_n_in || !clk_en_in)
		r.link != L_CFG |=> $stable(r.cfg) && $stable(r.bit_cyc) && $stable(r.unit))
		else $error("settings changed while running");
endmodule // rtu_serial_slave_link

// *** tb/rtu_host_model.sv ***
// host master model: drives command characters and gathers answer characters
module rtu_host_model #(
	parameter int BIT = 217
) (
	// clock
	input wire logic core_clk_in,
	// device line
	input wire logic tx_pin_in,
	input wire logic tx_drive_en_in,
	output logic rx_line_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] got_q[$];
	int bad_chars = 0;
	// spoils the parity of every sent character
	logic par_flip = 1'b0;

	function automatic logic [15:0] crc16(input logic [7:0] b[$]);
		logic [15:0] c;
		c = 16'hFFFF;
		foreach (b[i]) begin
			c = c ^ {8'h00, b[i]};
			for (int k = 0; k < 8; k++) begin
				c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
			end
		end
		return c;
	endfunction

	// each bit held one full bit time, changed just after an edge
	task automatic put_bit(input logic v);
		@(posedge core_clk_in);
		#1 rx_line_out = v;
		repeat (BIT - 1) @(posedge core_clk_in);
	endtask

	// flip spoils the check code on purpose; idle is the silence before the frame
	task automatic send(input logic [7:0] b[$], input logic [15:0] flip, input int idle);
		logic [15:0] c;
		c = crc16(b) ^ flip;
		b.push_back(c[7:0]);
		b.push_back(c[15:8]);
		repeat (idle) put_bit(1'b1);
		foreach (b[i]) begin
			put_bit(1'b0);
			for (int k = 0; k < 8; k++) begin
				put_bit(b[i][k]);
			end
			put_bit(~^b[i] ^ par_flip);
			put_bit(1'b1);
		end
	endtask

	// mid-bit sampling; only whole characters are kept
	initial begin : rx_side
		logic [7:0] d;
		rx_line_out = 1'b1;
		forever begin
			@(negedge tx_pin_in);
			repeat (BIT / 2) @(posedge core_clk_in);
			for (int k = 0; k < 8; k++) begin
				repeat (BIT) @(posedge core_clk_in);
				d[k] = tx_pin_in;
			end
			repeat (BIT) @(posedge core_clk_in);
			if (tx_pin_in !== ~^d || tx_drive_en_in !== 1'b1) bad_chars++;
			repeat (BIT) @(posedge core_clk_in);
			if (tx_pin_in !== 1'b1) bad_chars++;
			got_q.push_back(d);
		end
	end
endmodule // rtu_host_model

// *** tb/test_rtu_serial_slave_link.sv ***
// self-checking bench for the rtu slave link
module test_rtu_serial_slave_link import rtu_link_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int MSC = 20;
	localparam int BIT = 217;
	localparam int GAPW = 9000;
	localparam logic [7:0] UNIT = 8'h25;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic rx_line;
	logic tx_pin;
	logic tx_en;
	logic active;
	logic ready;
	logic [3:0] sw_a = 4'h5;
	logic [3:0] sw_b = 4'h6;
	link_cfg_t cfg = '{protocol: 1'b0, baud: BAUD_CODE_115K2, parity: PAR_ODD, delay_ms: 7'h03};
	rx_byte_t rxb;
	frame_info_t info;
	resp_req_t req = '0;
	tx_byte_t body = '0;
	int good_n = 0;
	int drop_n = 0;
	int byte_n = 0;
	logic [7:0] last_b = 8'h00;
	int g0, d0, b0;
	int failures = 0;
	int tests_run = 0;
	logic [7:0] q[$];
	logic [7:0] exp_q[$];

	rtu_serial_slave_link #(.MS_CYCLES(MSC)) DUT (
		.core_clk_in(clk), .rst_n_in(rst_n), .clk_en_in(1'b1),
		.rx_pin_in(rx_line), .tx_pin_out(tx_pin), .tx_drive_en_out(tx_en),
		.unit_address_switch_a_in(sw_a), .unit_address_switch_b_in(sw_b),
		.cfg_stored_in(cfg), .rx_byte_out(rxb), .frame_info_out(info),
		.link_active_out(active), .resp_req_in(req), .resp_byte_in(body),
		.resp_byte_ready_out(ready)
	);

	rtu_host_model #(.BIT(BIT)) host (
		.core_clk_in(clk), .tx_pin_in(tx_pin), .tx_drive_en_in(tx_en), .rx_line_out(rx_line)
	);

	initial begin
		forever #20 clk = ~clk;
	end

	always @(posedge clk) begin
		if (info.good === 1'b1) good_n++;
		if (info.drop === 1'b1) drop_n++;
		if (rxb.valid === 1'b1) byte_n++;
		if (rxb.valid === 1'b1) last_b = rxb.data;
	end

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask

	// a silent frame never ends the wait early, so the bound doubles as its verdict
	task automatic cmd(input logic [15:0] flip, input int idle);
		g0 = good_n;
		d0 = drop_n;
		b0 = byte_n;
		host.got_q.delete();
		host.send(q, flip, idle);
		for (int i = 0; i < GAPW && good_n == g0 && drop_n == d0; i++) @(posedge clk);
		#1;
	endtask

	task automatic expect_answer();
		logic [15:0] c;
		c = host.crc16(exp_q);
		exp_q.push_back(c[7:0]);
		exp_q.push_back(c[15:8]);
		for (int i = 0; i < 30000 && (host.got_q.size() < exp_q.size() || tx_en !== 1'b0); i++) @(posedge clk);
		check(16'(host.got_q.size()), 16'(exp_q.size()));
		foreach (exp_q[i]) if (i < host.got_q.size()) check({8'h00, host.got_q[i]}, {8'h00, exp_q[i]});
		check(16'(host.bad_chars), 16'h0000);
	endtask

	// valid held until ready is seen at an edge
	task automatic send_body(input logic [7:0] d, input logic l);
		int i;
		#1 body = '{valid: 1'b1, last: l, data: d};
		for (i = 0; i < 5000; i++) begin
			@(posedge clk);
			if (ready === 1'b1) break;
		end
		check(16'(i < 5000), 16'h0001);
	endtask

	task automatic t_bad_func();
		q = '{UNIT, 8'h41};
		cmd(16'h0000, 40);
		check(16'(good_n - g0), 16'h0001);
		check(16'(byte_n - b0), 16'h0002);
		exp_q = '{UNIT, 8'hC1, ERR_BAD_FUNC};
		expect_answer();
	endtask

	task automatic t_echo();
		int n;
		logic [15:0] c;
		q = '{UNIT, FC_ECHO, 8'h12, 8'h34};
		c = host.crc16(q);
		cmd(16'h0000, 40);
		check(16'(good_n - g0), 16'h0001);
		check({8'h00, last_b}, {8'h00, c[15:8]});
		check({8'h00, info.func}, {8'h00, FC_ECHO});
		check({15'h0, info.bcast}, 16'h0000);
		@(posedge clk);
		#1 req = '{start: 1'b1, error: 1'b0, code: FC_ECHO};
		@(posedge clk);
		#1 req = '0;
		for (n = 1; n < 400 && tx_en !== 1'b1; n++) begin
			@(posedge clk);
			#1;
		end
		check(16'(n >= 3 * MSC && n <= 3 * MSC + 4), 16'h0001);
		send_body(8'h12, 1'b0);
		send_body(8'h34, 1'b1);
		#1 body = '0;
		exp_q = '{UNIT, FC_ECHO, 8'h12, 8'h34};
		expect_answer();
	endtask

	task automatic t_bcast();
		q = '{ADDR_BCAST, FC_SINGLE, 8'hAA, 8'h55};
		cmd(16'h0000, 40);
		check(16'(good_n - g0), 16'h0001);
		check({15'h0, info.bcast}, 16'h0001);
		repeat (400) @(posedge clk);
		#1;
		check({15'h0, tx_en}, 16'h0000);
		check(16'(host.got_q.size()), 16'h0000);
	endtask

	task automatic t_foreign();
		q = '{8'h26, FC_READ, 8'h00, 8'h01};
		cmd(16'h0000, 2);
		check(16'(good_n - g0), 16'h0000);
		check(16'(drop_n - d0), 16'h0000);
		check(16'(byte_n - b0), 16'h0000);
	endtask

	task automatic t_bad_crc();
		q = '{UNIT, FC_READ, 8'h00, 8'h01};
		cmd(16'h0100, 2);
		check(16'(drop_n - d0), 16'h0001);
		check(16'(good_n - g0), 16'h0000);
		repeat (400) @(posedge clk);
		check(16'(host.got_q.size()), 16'h0000);
		host.par_flip = 1'b1;
		cmd(16'h0000, 2);
		host.par_flip = 1'b0;
		check(16'(drop_n - d0), 16'h0001);
		check(16'(good_n - g0), 16'h0000);
		// a frame too short: the address byte and its two check code bytes only
		q = '{UNIT};
		cmd(16'h0000, 2);
		check(16'(drop_n - d0), 16'h0001);
		check(16'(good_n - g0), 16'h0000);
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// generous bound: the whole sequence needs about 202k cycles
	initial begin
		repeat (250000) @(posedge clk);
		failures++;
		complete_run();
	end

	initial begin
		repeat (12) @(posedge clk);
		#1 rst_n = 1'b1;
		repeat (20) @(posedge clk);
		// later changes must not reach the running link
		#1 cfg = '{protocol: 1'b1, baud: BAUD_CODE_9K6, parity: PAR_NONE, delay_ms: 7'h00};
		sw_a = 4'hA;
		check({15'h0, active}, 16'h0001);
		t_bad_func();
		t_echo();
		t_bcast();
		t_foreign();
		t_bad_crc();
		complete_run();
	end
endmodule // test_rtu_serial_slave_link
